/* include/dcrm_regs.svh */
// Constants of the channel result mover
`ifndef DCRM_REGS_SVH
`define DCRM_REGS_SVH
`define DCRM_NCH 128
`define DCRM_CHW 7
`define DCRM_MAX_MOVES 16
`define DCRM_MOVE_W 5
`define DCRM_XFER_W 8
`define DCRM_IDX_W 13
`define DCRM_AW 32
`define DCRM_DW 256
`define DCRM_FIFO_DEPTH 16
`define DCRM_ENTRY_W 291
`endif

/* include/dcrm_pkg.sv */
// Types of the channel result mover
`include "dcrm_regs.svh"
package dcrm_pkg;
  typedef enum logic [2:0] {
    DCRM_W8,
    DCRM_W16,
    DCRM_W32,
    DCRM_W64,
    DCRM_W128,
    DCRM_W256
  } dcrm_width_t;
  typedef enum logic [1:0] {
    ST_ARB,
    ST_READ,
    ST_WAIT,
    ST_PUSH
  } dcrm_state_t;
endpackage

/* src/dcrm_fifo.sv */
// Write buffer between the move engine and the memory port
`timescale 1ns/1ns
`default_nettype none
module dcrm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire empty = (wptr == rptr);
  wire push = in_valid_in && !full;
  wire pop = !empty && out_ready_in;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rptr[AW-1:0]];
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) wptr <= wptr + {{AW{1'b0}}, 1'b1};
      if (pop) rptr <= rptr + {{AW{1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge clk_in) begin
    if (push) mem[wptr[AW-1:0]] <= in_data_in;
  end
endmodule
`default_nettype wire

/* src/dcrm_top.sv */
// Multi-channel move engine with converter request routing
// Notes on behaviour
// - Data moves from source to destination without any processor help.
// - A transaction is a count of transfers, each of one to 16 moves.
// - Channels may switch between transfers, never inside one.
// - Each move reads a datum of the chosen width, then writes it.
// - One engine serves all 128 channels; highest number wins arbitration.
// - A routed converter request starts a transaction on its channel.
// - A finished transaction pulses that channel's interrupt line.
// - With fixed addressing every move reuses the same source and destination.
`timescale 1ns/1ns
`default_nettype none
`include "dcrm_regs.svh"
module dcrm_top
  import dcrm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Channel requests
  input wire logic [`DCRM_NCH-1:0] chan_req_in,
  // Converter request routing
  input wire logic conv_req_in,
  input wire logic conv_to_engine_in,
  input wire logic [`DCRM_CHW-1:0] conv_chan_in,
  output logic conv_irq_out,
  // Transaction setup
  input wire logic [`DCRM_AW-1:0] src_base_in,
  input wire logic [`DCRM_AW-1:0] dst_base_in,
  input wire logic src_fixed_in,
  input wire logic dst_fixed_in,
  input wire dcrm_width_t move_width_in,
  input wire logic [`DCRM_MOVE_W-1:0] moves_in,
  input wire logic [`DCRM_XFER_W-1:0] transfers_in,
  // Source read port
  output logic src_rd_out,
  output logic [`DCRM_AW-1:0] src_addr_out,
  output logic [2:0] src_size_out,
  input wire logic src_rvalid_in,
  input wire logic [`DCRM_DW-1:0] src_rdata_in,
  // Destination write port
  output logic mem_wr_out,
  output logic [`DCRM_AW-1:0] mem_addr_out,
  output logic [2:0] mem_size_out,
  output logic [`DCRM_DW-1:0] mem_data_out,
  input wire logic mem_ready_in,
  // Channel completion interrupts
  output logic [`DCRM_NCH-1:0] chan_irq_out
);
  // ************************************************
  // Arbitration
  // ************************************************
  dcrm_state_t state;
  logic [`DCRM_NCH-1:0] pending;
  logic [`DCRM_NCH-1:0] busy;
  logic [`DCRM_NCH-1:0][`DCRM_XFER_W-1:0] tdone;
  logic [`DCRM_CHW-1:0] cur;
  logic [`DCRM_MOVE_W-1:0] move_idx;
  logic [`DCRM_DW-1:0] hold_data;
  logic [`DCRM_CHW-1:0] win;
  wire [`DCRM_NCH-1:0] cand = pending | busy;
  wire any_cand = |cand;
  wire grant = (state == ST_ARB) && any_cand;
  wire conv_route = conv_req_in && conv_to_engine_in;
  // Highest numbered candidate wins
  always_comb begin
    win = '0;
    for (int i = 0; i < `DCRM_NCH; i++) begin
      if (cand[i]) win = `DCRM_CHW'(i);
    end
  end
  // ************************************************
  // Move bookkeeping
  // ************************************************
  wire [`DCRM_MOVE_W-1:0] moves_eff = (moves_in == '0) ? `DCRM_MOVE_W'(1) :
      ((moves_in > `DCRM_MOVE_W'(`DCRM_MAX_MOVES)) ? `DCRM_MOVE_W'(`DCRM_MAX_MOVES) : moves_in);
  wire [`DCRM_XFER_W-1:0] xfers_eff = (transfers_in == '0) ? `DCRM_XFER_W'(1) : transfers_in;
  wire push_fire;
  wire last_move = (move_idx == moves_eff - `DCRM_MOVE_W'(1));
  wire xfer_end = push_fire && last_move;
  wire txn_end = xfer_end && (tdone[cur] + `DCRM_XFER_W'(1) == xfers_eff);
  wire [`DCRM_IDX_W-1:0] move_num = `DCRM_IDX_W'(tdone[cur]) * `DCRM_IDX_W'(moves_eff)
      + `DCRM_IDX_W'(move_idx);
  wire [`DCRM_AW-1:0] byte_off = `DCRM_AW'(move_num) << move_width_in;
  // Fixed addressing ignores the move count
  wire [`DCRM_AW-1:0] rd_addr = src_fixed_in ? src_base_in : src_base_in + byte_off;
  wire [`DCRM_AW-1:0] wr_addr = dst_fixed_in ? dst_base_in : dst_base_in + byte_off;
  // ************************************************
  // Per-channel state
  // ************************************************
  for (genvar g = 0; g < `DCRM_NCH; g++) begin : g_chan
    wire set_req = chan_req_in[g] || (conv_route && conv_chan_in == `DCRM_CHW'(g));
    wire accept = grant && (win == `DCRM_CHW'(g)) && !busy[g];
    wire mine = (cur == `DCRM_CHW'(g));
    always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
        pending[g] <= 1'b0;
        busy[g] <= 1'b0;
        tdone[g] <= '0;
        chan_irq_out[g] <= 1'b0;
      end else begin
        pending[g] <= set_req || (pending[g] && !accept);
        if (accept) busy[g] <= 1'b1;
        else if (txn_end && mine) busy[g] <= 1'b0;
        if (accept) tdone[g] <= '0;
        else if (xfer_end && mine) tdone[g] <= tdone[g] + `DCRM_XFER_W'(1);
        chan_irq_out[g] <= txn_end && mine;
      end
    end
  end
  // ************************************************
  // Move engine
  // ************************************************
  logic fifo_ready;
  logic fifo_out_valid;
  logic [`DCRM_ENTRY_W-1:0] fifo_out_data;
  wire fifo_in_valid = (state == ST_PUSH);
  assign push_fire = fifo_in_valid && fifo_ready;
  wire [`DCRM_ENTRY_W-1:0] entry = {wr_addr, 3'(move_width_in), hold_data};
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state <= ST_ARB;
      cur <= '0;
      move_idx <= '0;
      src_rd_out <= 1'b0;
      src_addr_out <= '0;
      src_size_out <= '0;
      hold_data <= '0;
    end else begin
      src_rd_out <= 1'b0;
      unique case (state)
        ST_ARB: begin
          if (any_cand) begin
            cur <= win;
            move_idx <= '0;
            state <= ST_READ;
          end
        end
        ST_READ: begin
          src_rd_out <= 1'b1;
          src_addr_out <= rd_addr;
          src_size_out <= 3'(move_width_in);
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (src_rvalid_in) begin
            hold_data <= src_rdata_in;
            state <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (fifo_ready) begin
            move_idx <= move_idx + `DCRM_MOVE_W'(1);
            state <= last_move ? ST_ARB : ST_READ;
          end
        end
      endcase
    end
  end
  dcrm_fifo #(.WIDTH(`DCRM_ENTRY_W), .DEPTH(`DCRM_FIFO_DEPTH)) u_fifo (
    .clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_ready),
    .in_data_in(entry),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(!mem_wr_out || mem_ready_in),
    .out_data_out(fifo_out_data)
  );
  // Output stage of the write port
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      mem_wr_out <= 1'b0;
      mem_addr_out <= '0;
      mem_size_out <= '0;
      mem_data_out <= '0;
      conv_irq_out <= 1'b0;
    end else begin
      conv_irq_out <= conv_req_in && !conv_to_engine_in;
      if (!mem_wr_out || mem_ready_in) begin
        mem_wr_out <= fifo_out_valid;
        if (fifo_out_valid) begin
          {mem_addr_out, mem_size_out, mem_data_out} <= fifo_out_data;
        end
      end
    end
  end
  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  a_pend_hold: assert property (chan_req_in[0] && !busy[0] |=> pending[0] || busy[0])
    else $error("request lost");
  a_read_issue: assert property (grant |=> ##1 src_rd_out)
    else $error("no read after grant");
  a_move_bound: assert property (state != ST_ARB |-> move_idx < moves_eff)
    else $error("move index out of range");
  a_no_preempt: assert property (state != ST_ARB && $past(state) != ST_ARB |-> $stable(cur))
    else $error("channel changed inside transfer");
  a_prio_top: assert property (grant |-> ((cand >> win) >> 1) == '0)
    else $error("lower channel won");
  a_irq_done: assert property (txn_end |=> chan_irq_out[cur] && state == ST_ARB)
    else $error("missing completion interrupt");
  a_fixed_src: assert property (src_rd_out && src_fixed_in |-> src_addr_out == src_base_in)
    else $error("fixed source address moved");
  a_conv_route: assert property (conv_route && !busy[conv_chan_in] |=> pending[$past(conv_chan_in)])
    else $error("converter request not routed");
  a_conv_cpu: assert property (conv_req_in && !conv_to_engine_in |=> conv_irq_out)
    else $error("converter interrupt missing");
  a_write_after_read: assert property (src_rd_out ##1 src_rvalid_in |=> state == ST_PUSH)
    else $error("read data not held");
  a_wr_hold: assert property (mem_wr_out && !mem_ready_in |=> mem_wr_out && $stable(mem_data_out))
    else $error("write dropped under back-pressure");
  a_irq_pulse: assert property (chan_irq_out[cur] |=> !chan_irq_out[$past(cur)])
    else $error("completion interrupt longer than one cycle");
  c_conv_txn: cover property (conv_route ##[1:40] chan_irq_out[conv_chan_in]);
  c_two_moves: cover property (xfer_end && move_idx == `DCRM_MOVE_W'(1));
  c_fifo_stall: cover property (fifo_in_valid && !fifo_ready);
  c_multi_xfer: cover property (xfer_end && !txn_end);
endmodule
`default_nettype wire

/* verif/dcrm_far_model.sv */
// Far side model: converter result source and memory sink
`timescale 1ns/1ns
`default_nettype none
module dcrm_far_model (
  // Clock
  input wire logic clk_in,
  // Scenario controls
  input wire logic new_res_in,
  input wire logic stall_in,
  // Engine side
  input wire logic src_rd_in,
  output logic conv_req_out,
  output logic src_rvalid_out,
  output logic [255:0] src_rdata_out,
  output logic mem_ready_out
);
  logic [31:0] result = 32'h9000_0FFF;
  logic [1:0] slow = 2'h0;
  logic [1:0] wait_cnt = 2'h0;
  logic pend = 1'b0;
  initial begin
    conv_req_out = 1'b0;
    src_rvalid_out = 1'b0;
    src_rdata_out = '0;
    mem_ready_out = 1'b0;
  end
  always @(posedge clk_in) begin
    conv_req_out <= new_res_in;
    src_rvalid_out <= 1'b0;
    src_rdata_out <= ~src_rdata_out;
    mem_ready_out <= !stall_in;
    if (new_res_in) result <= 32'h9000_0FFF;
    // Read latency cycles through one to four clocks
    if (src_rd_in) begin
      slow <= slow + 2'h1;
      if (slow == 2'h0) begin
        src_rvalid_out <= 1'b1;
        src_rdata_out <= {224'h0, result};
        result <= {1'b0, result[30:0]};
      end else begin
        pend <= 1'b1;
        wait_cnt <= slow - 2'h1;
      end
    end else if (pend && wait_cnt != 2'h0) begin
      wait_cnt <= wait_cnt - 2'h1;
    end else if (pend) begin
      pend <= 1'b0;
      src_rvalid_out <= 1'b1;
      src_rdata_out <= {224'h0, result};
      result <= {1'b0, result[30:0]};
    end
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
// Testbench of the channel result mover
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dcrm_pkg::*;
  typedef struct {int ch; int mv; int xf; bit fx; dcrm_width_t w; bit st;} dcrm_row_t;
  localparam logic [31:0] SB = 32'hF002_0700;
  localparam logic [31:0] DB = 32'h9000_0000;
  logic clk = 1'b0, rstn = 1'b0, newr = 1'b0, route = 1'b0, fx = 1'b0, stall = 1'b0;
  logic creq, src_rd, rv, wr, rdy, cirq;
  logic [127:0] req, irq;
  logic [6:0] cch;
  logic [4:0] mv;
  logic [7:0] xf;
  dcrm_width_t w;
  logic [31:0] saddr, waddr;
  logic [2:0] ssz, wsz;
  logic [255:0] rdata, wdata;
  logic [255:0] wq[$];
  logic [31:0] aq[$], sq[$];
  logic [127:0] iq[$];
  int err_total = 0, check_count = 0, nci = 0, n;
  dcrm_row_t rows[6] = '{'{1, 1, 1, 1, DCRM_W32, 0}, '{5, 16, 2, 0, DCRM_W8, 1},
    '{127, 3, 2, 0, DCRM_W256, 0}, '{0, 0, 0, 0, DCRM_W16, 0},
    '{9, 20, 1, 0, DCRM_W64, 0}, '{2, 2, 1, 0, DCRM_W128, 0}};
  dcrm_top DUT (.core_clk_in(clk), .resetn_in(rstn), .chan_req_in(req), .conv_req_in(creq),
    .conv_to_engine_in(route), .conv_chan_in(cch), .conv_irq_out(cirq), .src_base_in(SB),
    .dst_base_in(DB), .src_fixed_in(fx), .dst_fixed_in(fx), .move_width_in(w),
    .moves_in(mv), .transfers_in(xf), .src_rd_out(src_rd), .src_addr_out(saddr),
    .src_size_out(ssz), .src_rvalid_in(rv), .src_rdata_in(rdata), .mem_wr_out(wr),
    .mem_addr_out(waddr), .mem_size_out(wsz), .mem_data_out(wdata), .mem_ready_in(rdy),
    .chan_irq_out(irq));
  dcrm_far_model far (.clk_in(clk), .new_res_in(newr), .src_rd_in(src_rd), .stall_in(stall),
    .conv_req_out(creq), .src_rvalid_out(rv), .src_rdata_out(rdata), .mem_ready_out(rdy));
  initial forever #5 clk = ~clk;
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic settle(input int ni, input int nw);
    int k;
    k = 0;
    while ((iq.size() < ni || aq.size() < nw) && k < 3000) begin
      @(posedge clk);
      k++;
    end
    repeat (20) @(posedge clk);
    check(iq.size(), ni);
    check(aq.size(), nw);
  endtask
  always @(posedge clk) begin
    if (wr && rdy) begin
      aq.push_back(waddr);
      wq.push_back(wdata);
      check(wsz, w);
    end
    if (src_rd) begin
      sq.push_back(saddr);
      check(ssz, w);
    end
    if (irq != '0) iq.push_back(irq);
    if (cirq) nci++;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    req = '0;
    cch = 7'h01;
    mv = 5'h01;
    xf = 8'h01;
    w = DCRM_W32;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 check({src_rd, wr, irq, cirq}, '0);
    foreach (rows[r]) begin
      aq.delete();
      sq.delete();
      iq.delete();
      @(posedge clk);
      mv <= 5'(rows[r].mv);
      xf <= 8'(rows[r].xf);
      fx <= rows[r].fx;
      w <= rows[r].w;
      stall <= rows[r].st;
      req[rows[r].ch] <= 1'b1;
      @(posedge clk);
      req <= '0;
      if (rows[r].st) begin
        repeat (80) @(posedge clk);
        check(aq.size() + iq.size(), 0);
        stall <= 1'b0;
      end
      n = rows[r].mv == 0 ? 1 : rows[r].mv > 16 ? 16 : rows[r].mv;
      n = n * (rows[r].xf == 0 ? 1 : rows[r].xf);
      settle(1, n);
      check(iq[0], 128'h1 << rows[r].ch);
      foreach (aq[i]) begin
        check(sq[i], rows[r].fx ? SB : SB + (i << int'(rows[r].w)));
        check(aq[i], rows[r].fx ? DB : DB + (i << int'(rows[r].w)));
      end
      $display("row %0d done", r);
    end
    aq.delete();
    iq.delete();
    wq.delete();
    @(posedge clk);
    mv <= 5'h01;
    xf <= 8'h01;
    fx <= 1'b1;
    w <= DCRM_W32;
    route <= 1'b1;
    newr <= 1'b1;
    @(posedge clk);
    newr <= 1'b0;
    settle(1, 1);
    check(wq[0], {224'h0, 32'h9000_0FFF});
    req[1] <= 1'b1;
    @(posedge clk);
    req <= '0;
    settle(2, 2);
    check(wq[1], {224'h0, 32'h1000_0FFF});
    route <= 1'b0;
    nci = 0;
    newr <= 1'b1;
    @(posedge clk);
    newr <= 1'b0;
    settle(2, 2);
    check(nci, 1);
    $display("converter test done");
    aq.delete();
    iq.delete();
    @(posedge clk);
    req[3] <= 1'b1;
    req[127] <= 1'b1;
    @(posedge clk);
    req[127] <= 1'b0;
    repeat (2) @(posedge clk);
    req <= '0;
    settle(2, 2);
    check(iq[0], 128'h1 << 127);
    check(iq[1], 128'h1 << 3);
    $display("priority test done");
    @(posedge clk);
    req[4] <= 1'b1;
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 check({src_rd, wr, irq, cirq}, '0);
    aq.delete();
    iq.delete();
    repeat (40) @(posedge clk);
    check(aq.size() + iq.size(), 0);
    $display("reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
